// File: inc/sac_map.svh
`ifndef SAC_MAP_SVH
`define SAC_MAP_SVH

// ----------------------------------------------------------------------
// Clock and timing figures
// ----------------------------------------------------------------------
// System clock period in ns (20 MHz)
`define SAC_CLK_PERIOD_NS 50
// Least host clock pulse that wakes the device, ns
`define SAC_WAKE_PULSE_NS 50
// Wake pulse in clk cycles, rounded up, at least one
`define SAC_WAKE_CYC \
  (((`SAC_WAKE_PULSE_NS + `SAC_CLK_PERIOD_NS - 1) / `SAC_CLK_PERIOD_NS) > 0 ? \
   ((`SAC_WAKE_PULSE_NS + `SAC_CLK_PERIOD_NS - 1) / `SAC_CLK_PERIOD_NS) : 1)
// Wake-up time from light power-down, ns
`define SAC_LIGHT_WAKE_NS 350
// Light wake-up in clk cycles, rounded up
`define SAC_LIGHT_WAKE_CYC \
  ((`SAC_LIGHT_WAKE_NS + `SAC_CLK_PERIOD_NS - 1) / `SAC_CLK_PERIOD_NS)
// Typical acquire time, ns
`define SAC_ACQ_NS 200
// Acquire time in clk cycles, rounded up
`define SAC_ACQ_CYC ((`SAC_ACQ_NS + `SAC_CLK_PERIOD_NS - 1) / `SAC_CLK_PERIOD_NS)

// ----------------------------------------------------------------------
// Counts and widths
// ----------------------------------------------------------------------
// Result width in bits
`define SAC_RESULT_BITS 12
// Trigger pulses for light power-down
`define SAC_LIGHT_PULSES 3'h2
// Trigger pulses for deep power-down
`define SAC_DEEP_PULSES 3'h4
// Bit positions in the synchronised pin vector
`define SAC_PIN_SCLK 0
`define SAC_PIN_TRIG 1
`define SAC_PIN_CMP 2
`define SAC_PIN_NEG 3
`define SAC_PIN_REF 4
`define SAC_PIN_COUNT 5

`endif

// File: inc/sac_pkg.sv
package sac_pkg;

  // ----------------------------------------------------------------------
  // Control states, one-hot
  // ----------------------------------------------------------------------
  typedef enum logic [5:0] {
    SAC_ST_ACQUIRE  = 6'h01, // Tracking input, ready for a start
    SAC_ST_CONVERT  = 6'h02, // Bit search in progress
    SAC_ST_SHIFT    = 6'h04, // Result shifting out
    SAC_ST_LIGHT_PD = 6'h08, // Light power-down, reference kept
    SAC_ST_DEEP_PD  = 6'h10, // Deep power-down, all off
    SAC_ST_WARMUP   = 6'h20  // Waking, start not yet accepted
  } sac_state_e;

  // Result code word
  typedef logic [11:0] sac_code_t;

endpackage

// File: inc/sac_search_if.sv
`timescale 1ns/100ps
// Link between the sequencer and the bit search engine
interface sac_search_if #(
  parameter int BITS = 12
);
  logic start;             // Clear and begin a new search
  logic step;              // Take one comparator decision
  logic cmp;               // Comparator: input at or above trial
  logic [BITS-1:0] trial;  // Code presented to the DAC
  logic done;              // All bits decided

  modport seq (output start, output step, output cmp, input trial, input done);
  modport engine (input start, input step, input cmp, output trial, output done);
endinterface

// File: hdl/sac_pin_sync.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------------
// Two-flop synchroniser with rising edge detect
// ----------------------------------------------------------------------
module sac_pin_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Asynchronous pins
  input wire logic [WIDTH-1:0] pin_i,
  // Synchronised level and edge
  output logic [WIDTH-1:0] level_o,
  output logic [WIDTH-1:0] rise_o
);

  logic [WIDTH-1:0] meta_r; // First stage, read only by second
  logic [WIDTH-1:0] sync_r; // Second stage, safe to use
  logic [WIDTH-1:0] prev_r; // Delayed copy for edge detect

  // Synchroniser chain; edges come from stages two and three only
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      meta_r <= '0;
      sync_r <= '0;
      prev_r <= '0;
    end else begin
      meta_r <= pin_i;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  assign level_o = sync_r;
  assign rise_o = sync_r & ~prev_r;

endmodule

// File: hdl/sac_bit_search.sv
`timescale 1ns/100ps
`include "sac_map.svh"
// ----------------------------------------------------------------------
// Bit search engine: one decision per step, MSB first
// ----------------------------------------------------------------------
module sac_bit_search #(
  parameter int BITS = `SAC_RESULT_BITS
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Sequencer side
  sac_search_if.engine sif
);

  logic [BITS-1:0] code_r; // Bit search register contents
  logic [BITS-1:0] mark_r; // One-hot pointer to bit under test
  logic done_r;            // All bits decided

  // Keep or drop the tested bit and place the next trial bit
  function automatic logic [BITS-1:0] decide(input logic [BITS-1:0] code,
                                             input logic [BITS-1:0] mark,
                                             input logic keep);
    logic [BITS-1:0] res;
    res = keep ? code : (code & ~mark);
    res = res | (mark >> 1);
    return res;
  endfunction

  // Search register update
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      code_r <= '0;
      mark_r <= '0;
      done_r <= 1'b0;
    end else if (sif.start) begin
      // Cleared, then only the MSB on trial
      code_r <= {1'b1, {(BITS-1){1'b0}}};
      mark_r <= {1'b1, {(BITS-1){1'b0}}};
      done_r <= 1'b0;
    end else if (sif.step && !done_r && (mark_r != '0)) begin
      // One decision per step, pointer walks toward LSB
      code_r <= decide(code_r, mark_r, sif.cmp);
      mark_r <= mark_r >> 1;
      done_r <= mark_r[0];
    end
  end

  assign sif.trial = code_r;
  assign sif.done = done_r;

endmodule

// File: hdl/sac_adc_ctrl.sv
// ----------------------------------------------------------------------
// ----------------------------------------------------------------------
`timescale 1ns/100ps
`include "sac_map.svh"
module sac_adc_ctrl #(
  parameter int BITS = `SAC_RESULT_BITS
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Host serial pins
  input wire logic sclk_i,
  input wire logic trig_i,
  output logic dout_o,
  output logic dout_oe_n_o,
  // Analog front end status
  input wire logic cmp_i,
  input wire logic neg_supply_low_i,
  input wire logic ref_settled_i,
  // Analog front end control
  output logic [BITS-1:0] dac_code_o,
  output logic track_o,
  output logic acq_done_o,
  output logic bipolar_o,
  // Power state
  output logic light_pd_o,
  output logic deep_pd_o,
  output logic ready_o
);

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  localparam int WAKE_CYC = `SAC_WAKE_CYC;
  localparam int WARM_CYC = `SAC_LIGHT_WAKE_CYC;
  localparam int ACQ_CYC = `SAC_ACQ_CYC;

  sac_pkg::sac_state_e state_r;   // Control state
  sac_pkg::sac_state_e state_nxt; // Next control state

  logic [`SAC_PIN_COUNT-1:0] pin_lvl; // Synchronised pin levels
  logic [`SAC_PIN_COUNT-1:0] pin_rise; // Synchronised rising edges
  logic sclk_lvl;   // Host clock level
  logic sclk_rise;  // Host clock rising edge
  logic trig_rise;  // Trigger rising edge
  logic [2:0] pulse_cnt_r;  // Trigger pulses seen with clock low
  logic [2:0] pulse_cnt_nxt; // Next pulse count
  logic stepped_r;  // At least one decision made this conversion
  logic [3:0] wake_cnt_r;   // Host clock high time in power-down
  logic [3:0] warm_cnt_r;   // Wake-up delay counter
  logic [3:0] acq_cnt_r;    // Acquire time counter
  logic [BITS:0] shift_r;   // Flag plus result, MSB first
  logic [4:0] shift_cnt_r;  // Bits already shifted past by host clock edges
  logic bipolar_r;  // Bipolar mode, from supply detector
  logic wake_hit;   // Wake pulse long enough
  logic count_ok;   // Trigger pulse may be counted

  sac_search_if #(.BITS(BITS)) sif ();

  // ----------------------------------------------------------------------
  // Pin synchronisers and search engine
  // ----------------------------------------------------------------------
  sac_pin_sync #(
    .WIDTH(`SAC_PIN_COUNT)
  ) u_sync (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .pin_i({ref_settled_i, neg_supply_low_i, cmp_i, trig_i, sclk_i}),
    .level_o(pin_lvl),
    .rise_o(pin_rise)
  );

  sac_bit_search #(
    .BITS(BITS)
  ) u_search (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .sif(sif)
  );

  assign sclk_lvl = pin_lvl[`SAC_PIN_SCLK];
  assign sclk_rise = pin_rise[`SAC_PIN_SCLK];
  assign trig_rise = pin_rise[`SAC_PIN_TRIG];

  // Start only from acquire; later edges fall through
  assign sif.start = trig_rise && (state_r == sac_pkg::SAC_ST_ACQUIRE);
  // Each decision timed by a host clock edge
  assign sif.step = sclk_rise && (state_r == sac_pkg::SAC_ST_CONVERT);
  assign sif.cmp = pin_lvl[`SAC_PIN_CMP];

  // Encode raw search result for the current polarity mode
  function automatic logic [BITS-1:0] encode(input logic [BITS-1:0] raw,
                                             input logic bip);
    logic [BITS-1:0] res;
    res = raw;
    // Offset binary to two's complement is an MSB flip
    if (bip) begin
      res[BITS-1] = ~raw[BITS-1];
    end
    return res;
  endfunction

  // ----------------------------------------------------------------------
  // Power-down pulse counting
  // ----------------------------------------------------------------------
  // Counting is allowed before any decision; a started but unclocked
  // conversion is abandoned if the host turns it into a power-down request
  assign count_ok = !sclk_lvl && (((state_r == sac_pkg::SAC_ST_CONVERT) && !stepped_r) ||
                                  (state_r == sac_pkg::SAC_ST_ACQUIRE) ||
                                  (state_r == sac_pkg::SAC_ST_LIGHT_PD));

  // Next count, cleared by any rising host clock edge
  always_comb begin
    pulse_cnt_nxt = pulse_cnt_r;
    if (sclk_rise) begin
      pulse_cnt_nxt = 3'h0;
    end else if (trig_rise && count_ok && (pulse_cnt_r != `SAC_DEEP_PULSES)) begin
      pulse_cnt_nxt = pulse_cnt_r + 3'h1;
    end
  end

  // Pulse counter register
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      pulse_cnt_r <= 3'h0;
    end else begin
      pulse_cnt_r <= pulse_cnt_nxt;
    end
  end

  // Marks that the conversion has taken its first decision
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      stepped_r <= 1'b0;
    end else if (sif.start) begin
      stepped_r <= 1'b0;
    end else if (sif.step) begin
      stepped_r <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Wake detection and warm-up
  // ----------------------------------------------------------------------
  // High time of the host clock measured in power-down only
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      wake_cnt_r <= 4'h0;
    end else if (sclk_lvl && (state_r == sac_pkg::SAC_ST_LIGHT_PD ||
                              state_r == sac_pkg::SAC_ST_DEEP_PD)) begin
      if (wake_cnt_r != 4'hf) begin
        wake_cnt_r <= wake_cnt_r + 4'h1;
      end
    end else begin
      wake_cnt_r <= 4'h0;
    end
  end

  // Wake once the pulse has lasted its least width
  assign wake_hit = sclk_lvl && (wake_cnt_r >= 4'(WAKE_CYC - 1));

  // Warm-up delay after a wake; host is expected to allow this too
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      warm_cnt_r <= 4'h0;
    end else if (state_r != sac_pkg::SAC_ST_WARMUP) begin
      warm_cnt_r <= 4'h0;
    end else if (warm_cnt_r != 4'hf) begin
      warm_cnt_r <= warm_cnt_r + 4'h1;
    end
  end

  // ----------------------------------------------------------------------
  // Control state machine
  // ----------------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      sac_pkg::SAC_ST_ACQUIRE: begin
        // Start edge moves to hold and convert
        if (pulse_cnt_nxt == `SAC_LIGHT_PULSES) begin
          state_nxt = sac_pkg::SAC_ST_LIGHT_PD;
        end else if (sif.start) begin
          state_nxt = sac_pkg::SAC_ST_CONVERT;
        end
      end
      sac_pkg::SAC_ST_CONVERT: begin
        // Not restartable; only a power-down request may abandon it
        if (pulse_cnt_nxt == `SAC_LIGHT_PULSES) begin
          state_nxt = sac_pkg::SAC_ST_LIGHT_PD;
        end else if (sif.done) begin
          state_nxt = sac_pkg::SAC_ST_SHIFT;
        end
      end
      sac_pkg::SAC_ST_SHIFT: begin
        // Last bit has stood one host clock period
        if (sclk_rise && (shift_cnt_r == 5'(BITS))) begin
          state_nxt = sac_pkg::SAC_ST_ACQUIRE;
        end
      end
      sac_pkg::SAC_ST_LIGHT_PD: begin
        // Two more pulses deepen it, a clock pulse wakes
        if (pulse_cnt_nxt == `SAC_DEEP_PULSES) begin
          state_nxt = sac_pkg::SAC_ST_DEEP_PD;
        end else if (wake_hit) begin
          state_nxt = sac_pkg::SAC_ST_WARMUP;
        end
      end
      sac_pkg::SAC_ST_DEEP_PD: begin
        // Reference restarts on wake; the flag tracks its settling
        if (wake_hit) begin
          state_nxt = sac_pkg::SAC_ST_WARMUP;
        end
      end
      sac_pkg::SAC_ST_WARMUP: begin
        if (warm_cnt_r >= 4'(WARM_CYC - 1)) begin
          state_nxt = sac_pkg::SAC_ST_ACQUIRE;
        end
      end
      default: begin
        state_nxt = sac_pkg::SAC_ST_ACQUIRE;
      end
    endcase
  end

  // State register; reset lands in acquire, no command needed
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      state_r <= sac_pkg::SAC_ST_ACQUIRE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Polarity detection
  // ----------------------------------------------------------------------
  // Mode follows the supply detector, frozen during a conversion so a
  // result is never encoded half in one mode
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      bipolar_r <= 1'b0;
    end else if (state_r == sac_pkg::SAC_ST_ACQUIRE && !sif.start) begin
      bipolar_r <= pin_lvl[`SAC_PIN_NEG];
    end
  end

  // ----------------------------------------------------------------------
  // Serial output
  // ----------------------------------------------------------------------
  // Loads flag and code, then moves one bit per host clock edge
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      shift_r <= '0;
      shift_cnt_r <= 5'h0;
      dout_o <= 1'b0;
      dout_oe_n_o <= 1'b1;
    end else if (state_r == sac_pkg::SAC_ST_CONVERT && state_nxt == sac_pkg::SAC_ST_SHIFT) begin
      // Flag first, then the encoded code
      shift_r <= {pin_lvl[`SAC_PIN_REF], encode(sif.trial, bipolar_r)};
      dout_o <= pin_lvl[`SAC_PIN_REF];
      dout_oe_n_o <= 1'b0;
      shift_cnt_r <= 5'h0;
    end else if (state_r == sac_pkg::SAC_ST_SHIFT && sclk_rise) begin
      if (shift_cnt_r == 5'(BITS)) begin
        // Release the pin after the last bit
        dout_oe_n_o <= 1'b1;
        dout_o <= 1'b0;
      end else begin
        // Next bit on each host clock edge
        shift_r <= {shift_r[BITS-1:0], 1'b0};
        dout_o <= shift_r[BITS-1];
        shift_cnt_r <= shift_cnt_r + 5'h1;
      end
    end else if (state_r != sac_pkg::SAC_ST_SHIFT) begin
      // Not shifting: pin stays released
      dout_oe_n_o <= 1'b1;
      dout_o <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Acquire timing and registered status
  // ----------------------------------------------------------------------
  // Counts the time spent tracking since the last conversion
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      acq_cnt_r <= 4'h0;
      acq_done_o <= 1'b0;
    end else if (state_nxt != sac_pkg::SAC_ST_ACQUIRE) begin
      acq_cnt_r <= 4'h0;
      acq_done_o <= 1'b0;
    end else if (acq_cnt_r != 4'(ACQ_CYC)) begin
      acq_cnt_r <= acq_cnt_r + 4'h1;
      acq_done_o <= (acq_cnt_r == 4'(ACQ_CYC - 1));
    end
  end

  // Track, ready and power outputs registered from next state so they align with the state
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      track_o <= 1'b1;
      light_pd_o <= 1'b0;
      deep_pd_o <= 1'b0;
      ready_o <= 1'b1;
      bipolar_o <= 1'b0;
      dac_code_o <= '0;
    end else begin
      // Track in acquire, hold otherwise
      track_o <= (state_nxt == sac_pkg::SAC_ST_ACQUIRE);
      light_pd_o <= (state_nxt == sac_pkg::SAC_ST_LIGHT_PD);
      deep_pd_o <= (state_nxt == sac_pkg::SAC_ST_DEEP_PD);
      ready_o <= (state_nxt == sac_pkg::SAC_ST_ACQUIRE);
      bipolar_o <= bipolar_r;
      dac_code_o <= sif.trial;
    end
  end

endmodule

// File: test/sac_adc_ctrl_checker.sv
`timescale 1ns/100ps
// ----------------------------------------
// Port checker for the converter control
// ----------------------------------------
module sac_adc_ctrl_checker #(
  parameter int BITS = 12
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Host serial pins
  input wire logic sclk_i,
  input wire logic trig_i,
  input wire logic dout_o,
  input wire logic dout_oe_n_o,
  // Analog front end
  input wire logic cmp_i,
  input wire logic neg_supply_low_i,
  input wire logic ref_settled_i,
  input wire logic [BITS-1:0] dac_code_o,
  input wire logic track_o,
  input wire logic acq_done_o,
  input wire logic bipolar_o,
  // Power state
  input wire logic light_pd_o,
  input wire logic deep_pd_o,
  input wire logic ready_o
);
  // One domain, so one default clock
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);

  // First trial code of every search: MSB alone
  localparam logic [BITS-1:0] SEED_CODE = {1'b1, {(BITS-1){1'b0}}};

  // Power-down left, warm-up begins
  sequence s_pd_left;
    $fell(light_pd_o || deep_pd_o);
  endsequence
  // Result word starts to go out
  sequence s_shift_load;
    $fell(dout_oe_n_o);
  endsequence
  // Host clock held high while powered down
  sequence s_wake_req;
    ((light_pd_o || deep_pd_o) && sclk_i) [*2];
  endsequence

  idle_low_a: assert property (dout_oe_n_o |-> !dout_o)
    else $error("Data pin not low while released");
  start_track_a: assert property (ready_o && $rose(trig_i) |-> ##[1:6] !track_o)
    else $error("Trigger did not start a conversion");
  search_seed_a: assert property ($fell(track_o) |=> dac_code_o == SEED_CODE)
    else $error("Search did not start from a clear register");
  shift_hold_a: assert property (!dout_oe_n_o |-> !track_o && !ready_o)
    else $error("Tracking or ready while shifting");
  light_entry_a: assert property ($rose(light_pd_o) |-> !sclk_i && $past(trig_i, 2))
    else $error("Light power-down without trigger pulses");
  deep_entry_a: assert property ($rose(deep_pd_o) |-> $past(light_pd_o) && !sclk_i)
    else $error("Deep power-down not reached through light");
  wake_up_a: assert property (s_wake_req |-> ##[1:6] !(light_pd_o || deep_pd_o))
    else $error("Host clock did not wake the device");
  warm_up_a: assert property (s_pd_left |-> !ready_o [*6] ##[1:4] ready_o)
    else $error("Warm-up time wrong");
  acq_time_a: assert property ($rose(track_o) |-> !acq_done_o [*3] ##[1:3] acq_done_o)
    else $error("Acquire time wrong");
  bip_detect_a: assert property ((ready_o && neg_supply_low_i) [*5] |-> bipolar_o)
    else $error("Bipolar mode not detected");
  flag_first_a: assert property (s_shift_load |-> dout_o == ref_settled_i)
    else $error("First shifted bit is not the reference flag");
endmodule

bind sac_adc_ctrl sac_adc_ctrl_checker #(.BITS(BITS)) chk_u (
  .clk_i(clk_i), .resetn_i(resetn_i), .sclk_i(sclk_i), .trig_i(trig_i),
  .dout_o(dout_o), .dout_oe_n_o(dout_oe_n_o), .cmp_i(cmp_i),
  .neg_supply_low_i(neg_supply_low_i), .ref_settled_i(ref_settled_i),
  .dac_code_o(dac_code_o), .track_o(track_o), .acq_done_o(acq_done_o),
  .bipolar_o(bipolar_o), .light_pd_o(light_pd_o), .deep_pd_o(deep_pd_o),
  .ready_o(ready_o)
);

// File: test/sac_host_model.sv
`timescale 1ns/100ps
// ----------------------------------------
// Host model: serial clock, trigger, comparator
// ----------------------------------------
module sac_host_model (
  // Clock
  input wire logic clk_i,
  // Device side
  input wire logic [11:0] dac_code_i,
  input wire logic dout_i,
  input wire logic dout_oe_n_i,
  // Host pins and comparator
  output logic sclk_o,
  output logic trig_o,
  output logic cmp_o
);
  logic [11:0] target_r = 12'h000; // Analog input as a code
  logic last_r = 1'b0; // Last bit really driven
  logic wire_bit; // Level seen on the data line

  // No pull: a released line shows the inverse of its last bit
  assign wire_bit = dout_oe_n_i ? ~last_r : dout_i;
  // Input at or above the trial code keeps the bit
  assign cmp_o = (target_r >= dac_code_i);

  // Remember the driven level
  always_ff @(posedge clk_i) begin
    if (!dout_oe_n_i) begin
      last_r <= dout_i;
    end
  end

  // Pins idle low
  initial begin
    sclk_o = 1'b0;
    trig_o = 1'b0;
  end

  // Wait n falling edges
  task automatic idle(input int n);
    repeat (n) @(negedge clk_i);
  endtask

  // Trigger pulse, four cycles high, four low
  task automatic pulse_trig();
    trig_o = 1'b1;
    idle(4);
    trig_o = 1'b0;
    idle(4);
  endtask

  // One host clock period; data read before the rise
  task automatic sclk_pulse(output logic b);
    b = wire_bit;
    sclk_o = 1'b1;
    idle(4);
    sclk_o = 1'b0;
    idle(4);
  endtask

  // Short clock pulse, long enough to wake
  task automatic wake();
    sclk_o = 1'b1;
    idle(2);
    sclk_o = 1'b0;
    idle(3);
  endtask

  // Whole conversion, optional stray trigger after third decision
  task automatic convert(input logic [11:0] code, input logic stray,
                         output logic [12:0] word);
    logic b;
    target_r = code;
    pulse_trig();
    for (int k = 0; k < 12; k++) begin
      sclk_pulse(b);
      if (stray && k == 2) begin
        pulse_trig();
      end
    end
    // Flag then twelve code bits, last rise releases
    for (int k = 0; k < 13; k++) begin
      sclk_pulse(b);
      word = {word[11:0], b};
    end
  endtask
endmodule

// File: test/sac_adc_ctrl_tb.sv
`timescale 1ns/100ps
module sac_adc_ctrl_tb;
  // ----------------------------------------
  // Signals and counters
  // ----------------------------------------
  logic clk_i;
  logic resetn_i;
  logic sclk, trig, cmp; // Host pins and comparator
  logic neg_low; // Negative supply detector
  logic ref_ok; // Reference settled
  logic dout, dout_oe_n;
  logic [11:0] dac_code;
  logic track, acq_done, bipolar, light_pd, deep_pd, ready;
  int n_mismatch = 0;
  int n_tests = 0;

  // Device under test
  sac_adc_ctrl dut_u (
    .clk_i(clk_i), .resetn_i(resetn_i), .sclk_i(sclk), .trig_i(trig),
    .dout_o(dout), .dout_oe_n_o(dout_oe_n), .cmp_i(cmp),
    .neg_supply_low_i(neg_low), .ref_settled_i(ref_ok), .dac_code_o(dac_code),
    .track_o(track), .acq_done_o(acq_done), .bipolar_o(bipolar),
    .light_pd_o(light_pd), .deep_pd_o(deep_pd), .ready_o(ready)
  );

  // Host on the far side
  sac_host_model host_u (
    .clk_i(clk_i), .dac_code_i(dac_code), .dout_i(dout),
    .dout_oe_n_i(dout_oe_n), .sclk_o(sclk), .trig_o(trig), .cmp_o(cmp)
  );

  // 20 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input logic [12:0] seen, input logic [12:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Verdict and end of run
  task automatic conclude();
    $display("Compares %0d, mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Bounded wait for a settled acquire
  task automatic wait_ready();
    int k;
    k = 0;
    while (!(ready === 1'b1 && acq_done === 1'b1) && k < 40) begin
      @(negedge clk_i);
      k++;
    end
    if (k == 40) begin
      n_mismatch++;
      $display("Error at %0t: device never ready", $time);
      conclude();
    end
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  // Outputs just after reset
  task automatic t_reset();
    check({6'h00, track, ready, dout_oe_n, light_pd, deep_pd, bipolar, dout},
          13'h0070);
    check({1'b0, dac_code}, 13'h0000);
    $display("Reset state test done");
  endtask

  // One conversion in the given mode, flag and stray trigger
  task automatic t_sample_trigger(input logic [11:0] code, input logic bip,
                        input logic rdy, input logic stray);
    logic [12:0] word;
    neg_low = bip;
    ref_ok = rdy;
    host_u.idle(5);
    wait_ready();
    check({12'h000, bipolar}, {12'h000, bip});
    host_u.convert(code, stray, word);
    check(word, {rdy, bip ? {~code[11], code[10:0]} : code});
    wait_ready();
    check({12'h000, dout_oe_n}, 13'h0001);
    $display("Conversion test of %h done", code);
  endtask

  // Power-down by trigger pulses, then wake
  task automatic t_pd(input int n);
    wait_ready();
    repeat (n) host_u.pulse_trig();
    check({11'h000, light_pd, deep_pd}, (n == 2) ? 13'h0002 : 13'h0001);
    host_u.wake();
    check({11'h000, light_pd | deep_pd, ready}, 13'h0000);
    wait_ready();
    $display("Power-down test with %0d pulses done", n);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    resetn_i = 1'b0;
    neg_low = 1'b0;
    ref_ok = 1'b1;
    repeat (5) @(negedge clk_i);
    resetn_i = 1'b1;
    t_reset();
    t_sample_trigger(12'ha5c, 1'b0, 1'b1, 1'b0);
    t_sample_trigger(12'h000, 1'b0, 1'b1, 1'b1);
    t_sample_trigger(12'hfff, 1'b1, 1'b1, 1'b0);
    t_sample_trigger(12'h3c1, 1'b1, 1'b0, 1'b0);
    t_pd(2);
    t_sample_trigger(12'h7ff, 1'b0, 1'b1, 1'b0);
    t_pd(4);
    t_sample_trigger(12'h801, 1'b1, 1'b1, 1'b1);
    conclude();
  end
endmodule
